// *** mpw_pkg.sv ***
// Constants and types shared by the two-slave multiple PWM timer block.
// How it works
// R1: Master loads period, counts down, at zero raises interrupt and reloads in same step.
// R2: Each slave copies its duty value into its counter on master interrupt.
// R3: Slave output turns active one count clock after the master interrupt.
// R4: Slave counter at zero drives output inactive and stops until next trigger.
// R5: Polarity bit 0 gives active-high output, 1 gives active-low output.
// R6: Output enable 1 lets counting drive the output; 0 blocks it.
// R7: Software puts slaves in slave output mode and master in master mode.
// R8: Software keeps the master polarity bit at zero.
// R9: Software keeps the master output enable bit at zero.
// R10: Starting master and slaves together sets all enables; master interrupts at start.
// R11: Start and stop bits self-clear; stop clears the enable status bits.
// R12: Stop freezes every counter; slave outputs hold their present levels. The prescaler divider keeps running through a stop.
// R13: Software leaves modes, output modes and polarities alone while running.
// R14: Software rewrites period and duty only after a master interrupt.
// R15: All three count registers read at any time without disturbing counting.
// R16: Clearing unit enable resets all channel state and output bits.
// R17: Unit disabled stops its clock and ignores writes; enabling leaves channels stopped.
// R18: Enabling a slave output while stopped leaves the output level unchanged.
// R19: With output enable 0, writing the output bit drives it directly.
// R20: Software sets the master-select bit for masters on channels 2, 4, 6.
// R21: Software places master and slave channels only on the allowed channel numbers.
// R22: Period is master value plus one counts; duty is slave value over that.
// R23: Slave value above master value plus one gives a constant active output.
// R24: Software writes period and duty together right after one master interrupt.
// R25: Start or stop bits written in one access act on one common cycle.
package mpw_pkg;
    localparam int DW = 16;
    localparam int PSW = 4;
    localparam logic [3:0] A_UNIT_EN = 4'h0;
    localparam logic [3:0] A_PRESCALE = 4'h1;
    localparam logic [3:0] A_START = 4'h2;
    localparam logic [3:0] A_STOP = 4'h3;
    localparam logic [3:0] A_ENA_STAT = 4'h4;
    localparam logic [3:0] A_DATA_M = 4'h5;
    localparam logic [3:0] A_DATA_S1 = 4'h6;
    localparam logic [3:0] A_DATA_S2 = 4'h7;
    localparam logic [3:0] A_CNT_M = 4'h8;
    localparam logic [3:0] A_CNT_S1 = 4'h9;
    localparam logic [3:0] A_CNT_S2 = 4'ha;
    localparam logic [3:0] A_OUT_VAL = 4'hb;
    localparam logic [3:0] A_OUT_EN = 4'hc;
    localparam logic [3:0] A_OUT_LVL = 4'hd;
    localparam logic [3:0] A_OUT_MODE = 4'he;
    localparam int B_MST = 0;
    localparam int B_S1 = 1;
    localparam int B_S2 = 2;
    localparam logic [DW-1:0] RST_WORD = 16'h0000;
    localparam logic [2:0] RST_BITS = 3'h0;
    localparam logic [PSW-1:0] RST_PSEL = 4'h0;
    typedef enum logic [1:0] {M_STOP = 2'h0, M_LOAD = 2'h1, M_RUN = 2'h3} mpw_mst_t;
    typedef enum logic [1:0] {S_IDLE = 2'h0, S_ARM = 2'h1, S_ACT = 2'h3} mpw_slv_t;
endpackage : mpw_pkg

// *** mpw_chan_if.sv ***
// Interface carrying trigger, setup and events between control and one slave channel.
`timescale 1ns/1ps
interface mpw_chan_if;
    logic tick;
    logic trig;
    logic run_en;
    logic [mpw_pkg::DW-1:0] duty;
    logic [mpw_pkg::DW-1:0] cnt;
    logic go_act;
    logic go_inact;
    modport ctl (output tick, output trig, output run_en, output duty,
                 input cnt, input go_act, input go_inact);
    modport chan (input tick, input trig, input run_en, input duty,
                  output cnt, output go_act, output go_inact);
endinterface : mpw_chan_if

// *** mpw_prescale.sv ***
// Count clock enable generator dividing the clock by a power of two.
`timescale 1ns/1ps
module mpw_prescale #(parameter int W = 15) (
    input wire logic mclk, // Clock.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable.
    input wire logic clr, // Unit held in reset.
    input wire logic [mpw_pkg::PSW-1:0] sel, // Divide by two to this power.
    output logic tick // One cycle per count clock.
);
    logic [W-1:0] div_r;
    wire [W-1:0] lim = W'((32'h1 << sel) - 32'h1);
    wire at_lim = (div_r >= lim);
    assign tick = ce && !clr && at_lim;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            div_r <= '0;
        end else if (ce) begin
            div_r <= (clr || at_lim) ? '0 : div_r + W'(1);
        end
    end
endmodule : mpw_prescale

// *** mpw_slave.sv ***
// One-count slave channel that times the active width of one PWM output.
`timescale 1ns/1ps
module mpw_slave (
    input wire logic mclk, // Clock.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable.
    input wire logic clr, // Unit held in reset.
    mpw_chan_if.chan ch // Trigger, setup and events.
);
    mpw_pkg::mpw_slv_t st_r, st_nxt;
    logic [mpw_pkg::DW-1:0] cnt_r, cnt_nxt;
    wire step = ch.tick && ch.run_en;
    wire load = step && ch.trig;
    wire busy = (st_r != mpw_pkg::S_IDLE);
    wire zero = (cnt_r == '0);
    assign ch.cnt = cnt_r;
    assign ch.go_act = step && !load && busy && !zero; // R3
    // A count that meets zero on the retrigger tick still ends its pulse for one tick.
    assign ch.go_inact = step && busy && zero; // R4
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        if (load) begin
            cnt_nxt = ch.duty; // R2 R23
            st_nxt = mpw_pkg::S_ARM;
        end else if (step) begin
            case (st_r)
                mpw_pkg::S_ARM, mpw_pkg::S_ACT: begin
                    if (zero) begin
                        st_nxt = mpw_pkg::S_IDLE; // R4
                    end else begin
                        cnt_nxt = cnt_r - 16'h0001;
                        st_nxt = mpw_pkg::S_ACT;
                    end
                end
                default: st_nxt = st_r;
            endcase
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= mpw_pkg::S_IDLE;
            cnt_r <= mpw_pkg::RST_WORD;
        end else if (ce) begin
            st_r <= clr ? mpw_pkg::S_IDLE : st_nxt; // R16
            cnt_r <= clr ? mpw_pkg::RST_WORD : cnt_nxt; // R12
        end
    end
endmodule : mpw_slave

// *** mpw_top.sv ***
// Top of the multiple PWM timer: registers, master interval timer, two slaves.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module mpw_top (
    input wire logic mclk, // Clock, 100 MHz.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic clk_en, // Clock enable; low freezes all state.
    input wire logic [3:0] addr, // Register index.
    input wire logic [15:0] wdata, // Write data.
    input wire logic wr_en, // Write strobe.
    input wire logic rd_en, // Read strobe.
    output logic [15:0] rdata, // Read data, cycle after the strobe.
    output logic pwm1_out, // Slave one pin level.
    output logic pwm1_oe, // Slave one pin driven.
    output logic pwm2_out, // Slave two pin level.
    output logic pwm2_oe, // Slave two pin driven.
    output logic master_period_irq // Master interrupt pulse.
);
    localparam int DW = mpw_pkg::DW;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic en_r;
    logic [mpw_pkg::PSW-1:0] psel_r;
    logic [2:0] ena_r, ena_nxt;
    logic [DW-1:0] mdat_r, d1_r, d2_r;
    logic [DW-1:0] mcnt_r, mcnt_nxt;
    mpw_pkg::mpw_mst_t mst_r, mst_nxt;
    logic [2:0] oval_r, oval_nxt;
    logic [2:0] oen_r, olvl_r, omode_r;
    logic irq_r, oe1_r, oe2_r;
    logic [15:0] rdata_r;
    logic tick;

    mpw_chan_if c1 ();
    mpw_chan_if c2 ();

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Only the unit enable register accepts writes while the unit is off.
    wire wr_ok = wr_en && (en_r || addr == mpw_pkg::A_UNIT_EN); // R17
    wire wr_unit = wr_en && addr == mpw_pkg::A_UNIT_EN;
    wire wr_psel = wr_ok && addr == mpw_pkg::A_PRESCALE;
    wire wr_start = wr_ok && addr == mpw_pkg::A_START;
    wire wr_stop = wr_ok && addr == mpw_pkg::A_STOP;
    wire wr_dm = wr_ok && addr == mpw_pkg::A_DATA_M;
    wire wr_d1 = wr_ok && addr == mpw_pkg::A_DATA_S1;
    wire wr_d2 = wr_ok && addr == mpw_pkg::A_DATA_S2;
    wire wr_oval = wr_ok && addr == mpw_pkg::A_OUT_VAL;
    wire wr_oen = wr_ok && addr == mpw_pkg::A_OUT_EN;
    wire wr_olvl = wr_ok && addr == mpw_pkg::A_OUT_LVL;
    wire wr_omode = wr_ok && addr == mpw_pkg::A_OUT_MODE;
    wire [2:0] start_bits = wr_start ? wdata[2:0] : 3'h0;
    wire [2:0] stop_bits = wr_stop ? wdata[2:0] : 3'h0;
    wire unit_clr = !en_r;

    function automatic logic [15:0] pad3(input logic [2:0] v);
        pad3 = {13'h0000, v};
    endfunction : pad3

    // Count registers are plain taps and reading them changes nothing.
    logic [15:0] rd_mux;
    always_comb begin
        case (addr)
            mpw_pkg::A_UNIT_EN: rd_mux = {15'h0000, en_r};
            mpw_pkg::A_PRESCALE: rd_mux = {12'h000, psel_r};
            mpw_pkg::A_ENA_STAT: rd_mux = pad3(ena_r);
            mpw_pkg::A_DATA_M: rd_mux = mdat_r;
            mpw_pkg::A_DATA_S1: rd_mux = d1_r;
            mpw_pkg::A_DATA_S2: rd_mux = d2_r;
            mpw_pkg::A_CNT_M: rd_mux = mcnt_r; // R15
            mpw_pkg::A_CNT_S1: rd_mux = c1.cnt; // R15
            mpw_pkg::A_CNT_S2: rd_mux = c2.cnt; // R15
            mpw_pkg::A_OUT_VAL: rd_mux = pad3(oval_r);
            mpw_pkg::A_OUT_EN: rd_mux = pad3(oen_r);
            mpw_pkg::A_OUT_LVL: rd_mux = pad3(olvl_r);
            mpw_pkg::A_OUT_MODE: rd_mux = pad3(omode_r);
            default: rd_mux = 16'h0000;
        endcase
    end

    // ----------------------------------------------------------------
    // Count clock and master channel
    // ----------------------------------------------------------------
    mpw_prescale u_pre (
        .mclk(mclk),
        .reset_n(reset_n),
        .ce(clk_en),
        .clr(unit_clr),
        .sel(psel_r),
        .tick(tick)
    );

    // A start arms the load state, so the first tick after it behaves as a wrap.
    wire m_step = tick && ena_r[mpw_pkg::B_MST];
    wire m_wrap = (mst_r == mpw_pkg::M_LOAD) || (mcnt_r == '0);
    wire irq_evt = m_step && m_wrap; // R1

    always_comb begin
        mst_nxt = mst_r;
        mcnt_nxt = mcnt_r;
        if (start_bits[mpw_pkg::B_MST]) begin
            mst_nxt = mpw_pkg::M_LOAD; // R10
        end else if (m_step) begin
            case (mst_r)
                mpw_pkg::M_LOAD, mpw_pkg::M_RUN: begin
                    mst_nxt = mpw_pkg::M_RUN;
                    mcnt_nxt = m_wrap ? mdat_r : mcnt_r - 16'h0001; // R1 R22
                end
                default: mst_nxt = mst_r;
            endcase
        end
    end

    // Stop wins over start for a bit set in both, which one write cannot do.
    assign ena_nxt = (ena_r | start_bits) & ~stop_bits; // R10 R11 R25

    // ----------------------------------------------------------------
    // Slave channels
    // ----------------------------------------------------------------
    assign c1.tick = tick;
    assign c1.trig = irq_evt; // R2
    assign c1.run_en = ena_r[mpw_pkg::B_S1];
    assign c1.duty = d1_r;
    assign c2.tick = tick;
    assign c2.trig = irq_evt; // R2
    assign c2.run_en = ena_r[mpw_pkg::B_S2];
    assign c2.duty = d2_r;

    mpw_slave u_s1 (
        .mclk(mclk),
        .reset_n(reset_n),
        .ce(clk_en),
        .clr(unit_clr),
        .ch(c1.chan)
    );

    mpw_slave u_s2 (
        .mclk(mclk),
        .reset_n(reset_n),
        .ce(clk_en),
        .clr(unit_clr),
        .ch(c2.chan)
    );

    // ----------------------------------------------------------------
    // Output bits
    // ----------------------------------------------------------------
    wire [2:0] act_ev = {c2.go_act, c1.go_act, 1'b0};
    wire [2:0] inact_ev = {c2.go_inact, c1.go_inact, 1'b0};

    // Counting moves a bit only when enabled; software moves it only when not.
    always_comb begin
        oval_nxt = oval_r;
        for (int k = 0; k < 3; k++) begin
            if (!oen_r[k]) begin
                if (wr_oval) begin
                    oval_nxt[k] = wdata[k]; // R19
                end
            end else if (act_ev[k]) begin
                oval_nxt[k] = !olvl_r[k]; // R3 R5 R6
            end else if (inact_ev[k]) begin
                oval_nxt[k] = olvl_r[k]; // R4 R5 R6
            end
        end
    end

    // ----------------------------------------------------------------
    // Flip-flops
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            en_r <= 1'b0;
            rdata_r <= mpw_pkg::RST_WORD;
        end else if (clk_en) begin
            if (wr_unit) begin
                en_r <= wdata[0];
            end
            rdata_r <= rd_en ? rd_mux : mpw_pkg::RST_WORD;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            psel_r <= mpw_pkg::RST_PSEL;
            mdat_r <= mpw_pkg::RST_WORD;
            d1_r <= mpw_pkg::RST_WORD;
            d2_r <= mpw_pkg::RST_WORD;
            oen_r <= mpw_pkg::RST_BITS;
            olvl_r <= mpw_pkg::RST_BITS;
            omode_r <= mpw_pkg::RST_BITS;
        end else if (clk_en && unit_clr) begin
            psel_r <= mpw_pkg::RST_PSEL; // R16
            mdat_r <= mpw_pkg::RST_WORD;
            d1_r <= mpw_pkg::RST_WORD;
            d2_r <= mpw_pkg::RST_WORD;
            oen_r <= mpw_pkg::RST_BITS;
            olvl_r <= mpw_pkg::RST_BITS;
            omode_r <= mpw_pkg::RST_BITS;
        end else if (clk_en) begin
            if (wr_psel) psel_r <= wdata[mpw_pkg::PSW-1:0];
            if (wr_dm) mdat_r <= wdata;
            if (wr_d1) d1_r <= wdata;
            if (wr_d2) d2_r <= wdata;
            if (wr_oen) oen_r <= wdata[2:0]; // R18
            if (wr_olvl) olvl_r <= wdata[2:0];
            if (wr_omode) omode_r <= wdata[2:0];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ena_r <= mpw_pkg::RST_BITS;
            mst_r <= mpw_pkg::M_STOP;
            mcnt_r <= mpw_pkg::RST_WORD;
            oval_r <= mpw_pkg::RST_BITS;
            irq_r <= 1'b0;
            oe1_r <= 1'b0;
            oe2_r <= 1'b0;
        end else if (clk_en) begin
            ena_r <= unit_clr ? mpw_pkg::RST_BITS : ena_nxt; // R16 R17
            mst_r <= unit_clr ? mpw_pkg::M_STOP : mst_nxt;
            mcnt_r <= unit_clr ? mpw_pkg::RST_WORD : mcnt_nxt; // R12
            oval_r <= unit_clr ? mpw_pkg::RST_BITS : oval_nxt; // R16
            irq_r <= irq_evt;
            oe1_r <= en_r && omode_r[mpw_pkg::B_S1];
            oe2_r <= en_r && omode_r[mpw_pkg::B_S2];
        end
    end

    assign rdata = rdata_r;
    assign pwm1_out = oval_r[mpw_pkg::B_S1];
    assign pwm2_out = oval_r[mpw_pkg::B_S2];
    assign pwm1_oe = oe1_r;
    assign pwm2_oe = oe2_r;
    assign master_period_irq = irq_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    chk_master_reload: assert property ( // R1
        clk_en && en_r && irq_evt && !start_bits[0] |=> mcnt_r == $past(mdat_r))
        else $error("master did not reload its period on wrap");

    chk_master_down: assert property ( // R1
        clk_en && en_r && m_step && !m_wrap && !start_bits[0]
        |=> mcnt_r == $past(mcnt_r) - 16'h0001)
        else $error("master did not count down by one");

    chk_slave_load: assert property ( // R2
        clk_en && en_r && irq_evt && ena_r[1] |=> c1.cnt == $past(d1_r))
        else $error("slave one did not load its duty on trigger");

    chk_active_level: assert property ( // R3
        clk_en && en_r && c1.go_act && oen_r[1] |=> pwm1_out == !olvl_r[1])
        else $error("slave one output not active after trigger");

    chk_inactive_zero: assert property ( // R4
        clk_en && en_r && c2.go_inact && oen_r[2] |=> pwm2_out == olvl_r[2])
        else $error("slave two output not inactive at zero");

    chk_oe_block: assert property ( // R6
        clk_en && en_r && !oen_r[1] && !wr_oval |=> $stable(pwm1_out))
        else $error("disabled output changed without a write");

    chk_stop_clear: assert property ( // R11
        clk_en && wr_stop |=> (ena_r & $past(wdata[2:0])) == 3'h0)
        else $error("stop bits did not clear enable status");

    chk_stop_hold: assert property ( // R12
        en_r && !ena_r[0] && !start_bits[0] |=> $stable(mcnt_r))
        else $error("stopped master counter moved");

    chk_unit_reset: assert property ( // R16
        clk_en && !en_r |=> ena_r == 3'h0 && oval_r == 3'h0)
        else $error("unit disable did not clear channel state");

    chk_irq_start: assert property ( // R10
        clk_en && en_r && start_bits[0] ##1 (clk_en && tick && ena_r[0])
        |=> master_period_irq)
        else $error("master did not interrupt at start");

    chk_write_ignored: assert property ( // R17
        clk_en && !en_r && wr_en && addr == mpw_pkg::A_DATA_M
        |=> mdat_r == mpw_pkg::RST_WORD)
        else $error("write landed while the unit was off");

    chk_direct_write: assert property ( // R19
        clk_en && en_r && wr_oval && !oen_r[2]
        |=> pwm2_out == $past(wdata[2]))
        else $error("direct write did not reach slave two output");

    chk_s1_inactive: assert property ( // R4
        clk_en && en_r && c1.go_inact && oen_r[1]
        |=> pwm1_out == olvl_r[1])
        else $error("slave one output not inactive at zero");

    chk_s2_active: assert property ( // R3 R5
        clk_en && en_r && c2.go_act && oen_r[2]
        |=> pwm2_out == !olvl_r[2])
        else $error("slave two output not active after trigger");

    chk_slave_idle: assert property ( // R4
        clk_en && en_r && c1.go_inact && !irq_evt
        |=> c1.cnt == mpw_pkg::RST_WORD)
        else $error("slave one moved after reaching zero");

    chk_slave_hold: assert property ( // R12
        en_r && !ena_r[1]
        |=> $stable(c1.cnt))
        else $error("stopped slave one counter moved");

    chk_stop_outputs: assert property ( // R12
        clk_en && en_r && ena_r[2:1] == 2'b00 && oen_r[2:1] == 2'b11
        |=> $stable(pwm1_out) && $stable(pwm2_out))
        else $error("stopped slave outputs changed");

    chk_irq_pulse: assert property ( // R1
        clk_en && master_period_irq && !irq_evt
        |=> !master_period_irq)
        else $error("master interrupt lasted more than one cycle");

    chk_unit_pins: assert property ( // R16
        clk_en && !en_r
        |=> !pwm1_oe && !pwm2_oe)
        else $error("slave pins still driven with the unit off");

    // ----------------------------------------------------------------
    // Coverage
    // ----------------------------------------------------------------
    cov_irq: cover property (master_period_irq);
    cov_pwm_act: cover property (c1.go_act ##[1:40] c1.go_inact);
    cov_full_duty: cover property (irq_evt && c2.cnt != 16'h0000 && ena_r[2]);
    cov_freeze: cover property (!clk_en && ena_r[0]);
    cov_stop_run: cover property (wr_stop && ena_r == 3'h7);
endmodule : mpw_top

// *** mpw_top_tb.sv ***
// Self-checking testbench for the two-slave multiple PWM timer top.
`timescale 1ns/1ps
module mpw_top_tb;
    logic mclk;
    logic reset_n;
    logic clk_en;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [15:0] rdata;
    logic pwm1_out;
    logic pwm1_oe;
    logic pwm2_out;
    logic pwm2_oe;
    logic master_period_irq;
    int num_errors;
    int tests_run;
    int cyc = 0;
    logic [15:0] d;
    logic [15:0] d2;
    int n_irq;
    int n_hi1;
    int n_hi2;

    mpw_top dut (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pwm1_out(pwm1_out),
        .pwm1_oe(pwm1_oe), .pwm2_out(pwm2_out), .pwm2_oe(pwm2_oe),
        .master_period_irq(master_period_irq));

    // ------------------------------------------------------------
    // Clock, reset and hang guard
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors = num_errors + 1;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        @(negedge mclk);
        v = rdata;
    endtask : rd

    // Waits for the next interrupt pulse, leaving the caller in that cycle.
    task automatic wait_irq();
        logic found;
        found = 1'b0;
        for (int i = 0; i < 64 && !found; i++) begin
            @(negedge mclk);
            if (master_period_irq === 1'b1) begin
                found = 1'b1;
            end
        end
        check({15'h0, found}, 16'h1);
    endtask : wait_irq

    task automatic measure(input int n);
        n_irq = 0;
        n_hi1 = 0;
        n_hi2 = 0;
        repeat (n) begin
            @(negedge mclk);
            n_irq += (master_period_irq === 1'b1);
            n_hi1 += (pwm1_out === 1'b1);
            n_hi2 += (pwm2_out === 1'b1);
        end
    endtask : measure

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_unit_off();
        check({11'h0, pwm1_out, pwm1_oe, pwm2_out, pwm2_oe, master_period_irq}, 16'h0);
        wr(mpw_pkg::A_DATA_M, 16'h0003);
        wr(mpw_pkg::A_UNIT_EN, 16'h0001);
        rd(mpw_pkg::A_DATA_M, d);
        check(d, 16'h0000);
        rd(mpw_pkg::A_ENA_STAT, d);
        check(d, 16'h0000);
        rd(4'hf, d);
        check(d, 16'h0000);
    endtask : t_unit_off

    task automatic t_direct();
        wr(mpw_pkg::A_PRESCALE, 16'h0000);
        wr(mpw_pkg::A_DATA_M, 16'h0003);
        wr(mpw_pkg::A_DATA_S1, 16'h0002);
        wr(mpw_pkg::A_DATA_S2, 16'h0005);
        wr(mpw_pkg::A_OUT_MODE, 16'h0006);
        wr(mpw_pkg::A_OUT_LVL, 16'h0004);
        wr(mpw_pkg::A_OUT_VAL, 16'h0006);
        repeat (2) @(negedge mclk);
        check({12'h0, pwm1_out, pwm1_oe, pwm2_out, pwm2_oe}, 16'h000f);
        wr(mpw_pkg::A_OUT_VAL, 16'h0004);
        repeat (2) @(negedge mclk);
        check({14'h0, pwm1_out, pwm2_out}, 16'h0001);
        wr(mpw_pkg::A_OUT_EN, 16'h0006);
        repeat (5) @(negedge mclk);
        check({14'h0, pwm1_out, pwm2_out}, 16'h0001);
        rd(mpw_pkg::A_OUT_LVL, d);
        check(d, 16'h0004);
    endtask : t_direct

    task automatic t_run();
        wr(mpw_pkg::A_START, 16'h0007);
        rd(mpw_pkg::A_ENA_STAT, d);
        check(d, 16'h0007);
        rd(mpw_pkg::A_START, d);
        check(d, 16'h0000);
        wait_irq();
        wait_irq();
        @(negedge mclk);
        check({15'h0, pwm1_out}, 16'h0001);
        measure(12);
        check(16'(n_irq), 16'h0003);
        check(16'(n_hi1), 16'h0006);
        check(16'(n_hi2), 16'h0000);
        rd(mpw_pkg::A_CNT_M, d);
        check(d, 16'h0001);
        measure(8);
        check(16'(n_irq), 16'h0002);
    endtask : t_run

    // Holds the clock enable low for 21 cycles mid-period; every flop must freeze.
    task automatic t_freeze();
        rd(mpw_pkg::A_CNT_M, d);
        check(d, 16'h0003);
        @(posedge mclk);
        clk_en <= 1'b0;
        measure(21);
        check(16'(n_irq), 16'h0000);
        check(16'(n_hi1), 16'h0015);
        check(16'(n_hi2), 16'h0000);
        @(posedge mclk);
        clk_en <= 1'b1;
        rd(mpw_pkg::A_CNT_M, d);
        check(d, 16'h0000);
    endtask : t_freeze

    task automatic t_stop();
        logic p1;
        logic p2;
        wr(mpw_pkg::A_STOP, 16'h0007);
        rd(mpw_pkg::A_ENA_STAT, d);
        check(d, 16'h0000);
        p1 = pwm1_out;
        p2 = pwm2_out;
        rd(mpw_pkg::A_CNT_S1, d);
        measure(10);
        check(16'(n_irq), 16'h0000);
        rd(mpw_pkg::A_CNT_S1, d2);
        check(d2, d);
        check({14'h0, pwm1_out, pwm2_out}, {14'h0, p1, p2});
        wr(mpw_pkg::A_OUT_EN, 16'h0000);
        wr(mpw_pkg::A_OUT_VAL, 16'h0002);
        repeat (2) @(negedge mclk);
        check({14'h0, pwm1_out, pwm2_out}, 16'h0002);
    endtask : t_stop

    task automatic t_prescale();
        wr(mpw_pkg::A_PRESCALE, 16'h0001);
        wr(mpw_pkg::A_OUT_EN, 16'h0006);
        wr(mpw_pkg::A_START, 16'h0007);
        wait_irq();
        wr(mpw_pkg::A_DATA_M, 16'h0003);
        wr(mpw_pkg::A_DATA_S1, 16'h0001);
        wait_irq();
        measure(16);
        check(16'(n_irq), 16'h0002);
        check(16'(n_hi1), 16'h0004);
    endtask : t_prescale

    task automatic t_unit_reset();
        wr(mpw_pkg::A_UNIT_EN, 16'h0000);
        repeat (2) @(negedge mclk);
        check({12'h0, pwm1_out, pwm1_oe, pwm2_out, pwm2_oe}, 16'h0000);
        rd(mpw_pkg::A_ENA_STAT, d);
        check(d, 16'h0000);
        wr(mpw_pkg::A_UNIT_EN, 16'h0001);
        rd(mpw_pkg::A_DATA_M, d);
        check(d, 16'h0000);
        rd(mpw_pkg::A_ENA_STAT, d);
        check(d, 16'h0000);
    endtask : t_unit_reset

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        num_errors = 0;
        tests_run = 0;
        reset_n = 1'b0;
        clk_en = 1'b1;
        addr = 4'h0;
        wdata = 16'h0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        @(negedge mclk);
        t_unit_off();
        t_direct();
        t_run();
        t_freeze();
        t_stop();
        t_prescale();
        t_unit_reset();
        test_done();
    end
endmodule : mpw_top_tb
